/* hw/miet_alu.sv */
// Purpose: combinational result, flag and skip logic for one instruction
// Assumes: operands stable for the execute cycle
// Notes:   table reads only raise tbl_o; the core does the fetch
`timescale 1ns/1ps
module miet_alu (
	input  wire logic [3:0] op_i,
	input  wire logic [7:0] acc_i,
	input  wire logic [7:0] mem_i,
	input  wire logic [7:0] lit_i,
	input  wire logic [2:0] bsel_i,
	input  wire logic [3:0] flags_i,
	output logic      [7:0] acc_o,
	output logic      [7:0] mem_o,
	output logic      [3:0] flags_o,
	output logic            acc_we_o,
	output logic            mem_we_o,
	output logic            skip_o,
	output logic            tbl_o
);

	function automatic logic is_nil(input logic [7:0] v);
		return v == 8'h00;
	endfunction

	logic [8:0] diff;
	logic [4:0] ndiff;

	always_comb begin
		diff     = {1'b0, acc_i} - {1'b0, lit_i};
		ndiff    = {1'b0, acc_i[3:0]} - {1'b0, lit_i[3:0]};
		acc_o    = acc_i;
		mem_o    = mem_i;
		flags_o  = flags_i;
		acc_we_o = 1'b0;
		mem_we_o = 1'b0;
		skip_o   = 1'b0;
		tbl_o    = 1'b0;
		case (op_i)
			miet_pkg::OP_SUB_IMM: begin
				acc_o    = diff[7:0];
				acc_we_o = 1'b1;
				flags_o[miet_pkg::FLAG_BORROW_INV] = ~diff[8];
				flags_o[miet_pkg::FLAG_NIB_CARRY]  = ~ndiff[4];
				flags_o[miet_pkg::FLAG_WRAP] = (acc_i[7] ^ lit_i[7]) & (acc_i[7] ^ diff[7]);
				flags_o[miet_pkg::FLAG_NIL]  = is_nil(diff[7:0]);
			end
			miet_pkg::OP_SWAP: begin
				mem_o    = {mem_i[3:0], mem_i[7:4]};
				mem_we_o = 1'b1;
			end
			miet_pkg::OP_SWAP_W: begin
				acc_o    = {mem_i[3:0], mem_i[7:4]};
				acc_we_o = 1'b1;
			end
			miet_pkg::OP_SZ: skip_o = is_nil(mem_i);
			miet_pkg::OP_SZA: begin
				acc_o    = mem_i;
				acc_we_o = 1'b1;
				skip_o   = is_nil(mem_i);
			end
			miet_pkg::OP_SZ_BIT: skip_o = ~mem_i[bsel_i];
			miet_pkg::OP_TRD_CUR,
			miet_pkg::OP_TRD_LAST: tbl_o = 1'b1;
			miet_pkg::OP_XOR_W: begin
				acc_o    = acc_i ^ mem_i;
				acc_we_o = 1'b1;
				flags_o[miet_pkg::FLAG_NIL] = is_nil(acc_i ^ mem_i);
			end
			miet_pkg::OP_XOR_M: begin
				mem_o    = acc_i ^ mem_i;
				mem_we_o = 1'b1;
				flags_o[miet_pkg::FLAG_NIL] = is_nil(acc_i ^ mem_i);
			end
			miet_pkg::OP_XOR_IMM: begin
				acc_o    = acc_i ^ lit_i;
				acc_we_o = 1'b1;
				flags_o[miet_pkg::FLAG_NIL] = is_nil(acc_i ^ lit_i);
			end
			default: ;
		endcase
	end

endmodule // miet_alu

/* hw/miet_core.sv */
// Purpose: execute tail of an 8-bit core, registers over classic Wishbone
// Assumes: program memory answers prog_addr_o in the same cycle that it is presented
// Notes:
// Notes on behaviour
// - subtract literal, set wrap/nil/nibble/borrow flags
// - in-place swap exchanges byte nibbles, flags kept
// - swap into working register, byte untouched
// - skip next instruction when byte is zero
// - a taken skip costs one dummy cycle
// - copy byte to working, skip if zero
// - skip next instruction when chosen bit zero
// - current-page table read fills byte and latch
// - final-page table read fills byte and latch
// - xor into working register, nil flag only
// - xor into data byte, nil flag only
// - xor literal into working, nil flag only
//
// Chosen here: the Wishbone register port and the placing of the registers.
`timescale 1ns/1ps
module miet_core #(
	parameter int DEPTH = 96,
	parameter int PAW   = 11,
	parameter int PW    = 15
) (
	input  wire logic          ref_clk_i,
	input  wire logic          rst_n_i,
	input  wire logic          wb_cyc_i,
	input  wire logic          wb_stb_i,
	input  wire logic          wb_we_i,
	input  wire logic [9:0]    wb_adr_i,
	input  wire logic [3:0]    wb_sel_i,
	input  wire logic [31:0]   wb_dat_i,
	output logic      [31:0]   wb_dat_o,
	output logic               wb_ack_o,
	output logic      [PAW-1:0] prog_addr_o,
	output logic               prog_rd_o,
	input  wire logic [PW-1:0] prog_data_i,
	output logic               busy_o
);

	localparam int MAW = 7;
	localparam int PGW = PAW - 8;
	localparam int MEM_WIN_LSB_C = miet_pkg::MEM_WIN_LSB;

	typedef struct packed {
		miet_pkg::miet_state_e    st;
		logic [7:0]               acc;
		logic [3:0]               flags;
		logic [7:0]               table_pointer;
		logic [PW-9:0]            table_high_latch;
		logic [PAW-1:0]           pc;
		logic [3:0]               op;
		logic [2:0]               bsel;
		logic [MAW-1:0]           maddr;
		logic [7:0]               lit;
		logic                     skipped;
		logic                     busy;
		logic                     ack;
		logic [31:0]              rdata;
		logic [PAW-1:0]           paddr;
		logic                     prd;
		logic [DEPTH-1:0][7:0]    mem;
	} miet_state_s;

	miet_state_s q;
	miet_state_s d;

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic logic [31:0] merge_sel(input logic [31:0] old_v, input logic [31:0] new_v,
	                                          input logic [3:0] sel);
		logic [31:0] r;
		r = old_v;
		for (int b = 0; b < 4; b++) begin
			if (sel[b])
				r[b*8 +: 8] = new_v[b*8 +: 8];
		end
		return r;
	endfunction

	function automatic logic in_mem(input logic [MAW-1:0] a);
		return 32'(a) < 32'(DEPTH);
	endfunction

	logic           acc_req;
	logic           bus_wr;
	logic           is_mem;
	logic [MAW-1:0] bus_idx;
	logic [7:0]     cur_byte;
	logic [PGW-1:0] cur_page;
	logic [PW-9:0]  prog_hi;
	logic [31:0]    rd_word;
	logic [7:0]     alu_acc;
	logic [7:0]     alu_mem;
	logic [3:0]     alu_flags;
	logic           alu_acc_we;
	logic           alu_mem_we;
	logic           alu_skip;
	logic           alu_tbl;

	assign acc_req  = wb_cyc_i & wb_stb_i;
	assign bus_wr   = acc_req & wb_we_i & q.ack;
	assign is_mem   = wb_adr_i[9:MEM_WIN_LSB_C] == miet_pkg::MEM_WINDOW;
	assign bus_idx  = MAW'(wb_adr_i[MEM_WIN_LSB_C-1:2]);
	assign cur_byte = in_mem(q.maddr) ? q.mem[q.maddr] : 8'h00;
	assign cur_page = q.pc[PAW-1:8];
	assign prog_hi  = prog_data_i[PW-1:8];

	miet_alu u_alu (
		.op_i     (q.op),
		.acc_i    (q.acc),
		.mem_i    (cur_byte),
		.lit_i    (q.lit),
		.bsel_i   (q.bsel),
		.flags_i  (q.flags),
		.acc_o    (alu_acc),
		.mem_o    (alu_mem),
		.flags_o  (alu_flags),
		.acc_we_o (alu_acc_we),
		.mem_we_o (alu_mem_we),
		.skip_o   (alu_skip),
		.tbl_o    (alu_tbl)
	);

	// ----------------------------------------------------------------
	// read mux
	// ----------------------------------------------------------------
	always_comb begin
		rd_word = 32'h00000000;
		if (is_mem) begin
			if (in_mem(bus_idx))
				rd_word[7:0] = q.mem[bus_idx];
		end else begin
			case (wb_adr_i)
				miet_pkg::REG_WORKING:  rd_word[7:0] = q.acc;
				miet_pkg::REG_FLAGS:    rd_word[miet_pkg::FLAG_W-1:0] = q.flags;
				miet_pkg::REG_TBL_PTR:  rd_word[7:0] = q.table_pointer;
				miet_pkg::REG_TBL_HIGH: rd_word[PW-9:0] = q.table_high_latch;
				miet_pkg::REG_PROG_CNT: rd_word[PAW-1:0] = q.pc;
				miet_pkg::REG_INSTR: begin
					rd_word[miet_pkg::OP_LSB +: miet_pkg::OP_W]       = q.op;
					rd_word[miet_pkg::BSEL_LSB +: miet_pkg::BSEL_W]   = q.bsel;
					rd_word[miet_pkg::MADDR_LSB +: MAW]               = q.maddr;
					rd_word[miet_pkg::LIT_LSB +: 8]                   = q.lit;
				end
				miet_pkg::REG_STATUS: begin
					rd_word[miet_pkg::STAT_BUSY] = q.busy;
					rd_word[miet_pkg::STAT_SKIP] = q.skipped;
				end
				default: rd_word = 32'h00000000;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		logic [31:0] w;
		w      = 32'h00000000;
		d      = q;
		d.ack  = acc_req & ~q.ack;
		d.prd  = 1'b0;
		if (acc_req & ~q.ack)
			d.rdata = rd_word;
		// software writes land first so that execution updates win
		if (bus_wr) begin
			if (is_mem) begin
				if (in_mem(bus_idx) && wb_sel_i[0])
					d.mem[bus_idx] = wb_dat_i[7:0];
			end else begin
				case (wb_adr_i)
					miet_pkg::REG_WORKING: begin
						w     = merge_sel({24'h000000, q.acc}, wb_dat_i, wb_sel_i);
						d.acc = w[7:0];
					end
					miet_pkg::REG_FLAGS: begin
						w       = merge_sel({28'h0000000, q.flags}, wb_dat_i, wb_sel_i);
						d.flags = w[miet_pkg::FLAG_W-1:0];
					end
					miet_pkg::REG_TBL_PTR: begin
						w      = merge_sel({24'h000000, q.table_pointer}, wb_dat_i, wb_sel_i);
						d.table_pointer = w[7:0];
					end
					miet_pkg::REG_PROG_CNT: begin
						w    = merge_sel({{(32-PAW){1'b0}}, q.pc}, wb_dat_i, wb_sel_i);
						d.pc = w[PAW-1:0];
					end
					miet_pkg::REG_INSTR: begin
						// a new instruction is ignored while one is running
						if (q.st == miet_pkg::ST_IDLE) begin
							d.op    = wb_dat_i[miet_pkg::OP_LSB +: miet_pkg::OP_W];
							d.bsel  = wb_dat_i[miet_pkg::BSEL_LSB +: miet_pkg::BSEL_W];
							d.maddr = wb_dat_i[miet_pkg::MADDR_LSB +: MAW];
							d.lit   = wb_dat_i[miet_pkg::LIT_LSB +: 8];
							d.st    = miet_pkg::ST_EXEC;
						end
					end
					default: ;
				endcase
			end
		end
		case (q.st)
			miet_pkg::ST_IDLE: ;
			miet_pkg::ST_EXEC: begin
				d.flags = alu_flags;
				if (alu_acc_we)
					d.acc = alu_acc;
				if (alu_mem_we && in_mem(q.maddr))
					d.mem[q.maddr] = alu_mem;
				d.skipped = alu_skip;
				if (alu_tbl) begin
					if (q.op == miet_pkg::OP_TRD_LAST)
						d.paddr = {{PGW{1'b1}}, q.table_pointer};
					else
						d.paddr = {cur_page, q.table_pointer};
					d.prd = 1'b1;
					d.st  = miet_pkg::ST_TABLE;
				end else if (alu_skip) begin
					d.st = miet_pkg::ST_SKIP;
				end else begin
					d.pc = q.pc + PAW'(1);
					d.st = miet_pkg::ST_IDLE;
				end
			end
			miet_pkg::ST_TABLE: begin
				if (in_mem(q.maddr))
					d.mem[q.maddr] = prog_data_i[7:0];
				d.table_high_latch = prog_hi;
				d.pc   = q.pc + PAW'(1);
				d.st   = miet_pkg::ST_IDLE;
			end
			miet_pkg::ST_SKIP: begin
				d.pc = q.pc + PAW'(2);
				d.st = miet_pkg::ST_IDLE;
			end
			default: d.st = miet_pkg::ST_IDLE;
		endcase
		d.busy = d.st != miet_pkg::ST_IDLE;
	end

	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i)
			q <= '0;
		else
			q <= d;
	end

	assign wb_dat_o    = q.rdata;
	assign wb_ack_o    = q.ack;
	assign prog_addr_o = q.paddr;
	assign prog_rd_o   = q.prd;
	assign busy_o      = q.busy;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (!rst_n_i);

	logic ex;
	assign ex = q.st == miet_pkg::ST_EXEC;

	sequence s_dummy_then_idle;
		q.st == miet_pkg::ST_SKIP ##1 q.st == miet_pkg::ST_IDLE;
	endsequence

	sequence s_no_dummy;
		q.st == miet_pkg::ST_IDLE;
	endsequence

	a_sub_borrow_flag: assert property (ex && q.op == miet_pkg::OP_SUB_IMM |=>
		q.flags[miet_pkg::FLAG_BORROW_INV] == ($past(q.acc) >= $past(q.lit))
		&& q.acc == 8'($past(q.acc) - $past(q.lit)))
		else $error("subtract result or borrow flag wrong");

	a_swap_in_place: assert property (ex && q.op == miet_pkg::OP_SWAP && in_mem(q.maddr) |=>
		{q.mem[q.maddr][3:0], q.mem[q.maddr][7:4]} == $past(cur_byte) && $stable(q.flags))
		else $error("in-place nibble exchange wrong");

	a_swap_to_working: assert property (ex && q.op == miet_pkg::OP_SWAP_W |=>
		{q.acc[3:0], q.acc[7:4]} == $past(cur_byte) && $stable(q.flags))
		else $error("nibble exchange into working register wrong");

	a_zero_skip: assert property (ex && q.op == miet_pkg::OP_SZ && cur_byte == 8'h00 |=>
		s_dummy_then_idle)
		else $error("zero byte did not skip");

	a_nonzero_proceed: assert property (ex && !alu_tbl && !alu_skip |=> s_no_dummy)
		else $error("dummy cycle without skip");

	a_skip_pc_step: assert property (ex && alu_skip |=>
		q.st == miet_pkg::ST_SKIP ##1 q.pc == PAW'($past(q.pc, 2) + PAW'(2)))
		else $error("skip did not advance by two words");

	a_copy_then_test: assert property (ex && q.op == miet_pkg::OP_SZA |=>
		q.acc == $past(cur_byte) && q.skipped == ($past(cur_byte) == 8'h00))
		else $error("copy and test wrong");

	a_bit_zero_skip: assert property (ex && q.op == miet_pkg::OP_SZ_BIT |=>
		q.skipped == !$past(cur_byte[q.bsel]) && $stable(q.acc))
		else $error("bit test skip wrong");

	a_table_page_cur: assert property (ex && q.op == miet_pkg::OP_TRD_CUR |=>
		q.paddr == {$past(cur_page), $past(q.table_pointer)} && q.prd
		##1 q.table_high_latch == $past(prog_hi))
		else $error("current page table read wrong");

	a_table_page_last: assert property (ex && q.op == miet_pkg::OP_TRD_LAST |=>
		q.paddr[PAW-1:8] == {PGW{1'b1}} && q.paddr[7:0] == $past(q.table_pointer))
		else $error("final page table read address wrong");

	a_xor_nil_flag: assert property (ex && (q.op == miet_pkg::OP_XOR_W || q.op == miet_pkg::OP_XOR_IMM) |=>
		q.flags[miet_pkg::FLAG_NIL] == (q.acc == 8'h00)
		&& q.flags[miet_pkg::FLAG_BORROW_INV] == $past(q.flags[miet_pkg::FLAG_BORROW_INV]))
		else $error("xor nil flag wrong");

	a_xor_mem_store: assert property (ex && q.op == miet_pkg::OP_XOR_M && in_mem(q.maddr) |=>
		q.mem[q.maddr] == ($past(q.acc) ^ $past(cur_byte))
		&& q.flags[miet_pkg::FLAG_NIL] == (q.mem[q.maddr] == 8'h00))
		else $error("xor to memory wrong");

endmodule // miet_core

/* hw/miet_pkg.sv */
// Purpose: shared constants for the instruction execute tail
// Assumes: 32-bit classic Wishbone register access, byte addresses
// Notes:   opcode values are those of the instruction register op field
package miet_pkg;

	// ----------------------------------------------------------------
	// register map (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [9:0] REG_WORKING   = 10'h000;
	localparam logic [9:0] REG_FLAGS     = 10'h004;
	localparam logic [9:0] REG_TBL_PTR   = 10'h008;
	localparam logic [9:0] REG_TBL_HIGH  = 10'h00C;
	localparam logic [9:0] REG_PROG_CNT  = 10'h010;
	localparam logic [9:0] REG_INSTR     = 10'h014;
	localparam logic [9:0] REG_STATUS    = 10'h018;
	localparam logic [1:0] MEM_WINDOW    = 2'h1;
	localparam int         MEM_WIN_LSB   = 8;

	// ----------------------------------------------------------------
	// flag bits
	// ----------------------------------------------------------------
	localparam int FLAG_BORROW_INV = 0;
	localparam int FLAG_NIB_CARRY  = 1;
	localparam int FLAG_NIL        = 2;
	localparam int FLAG_WRAP       = 3;
	localparam int FLAG_W          = 4;

	// ----------------------------------------------------------------
	// instruction and status register fields
	// ----------------------------------------------------------------
	localparam int OP_LSB    = 0;
	localparam int OP_W      = 4;
	localparam int BSEL_LSB  = 4;
	localparam int BSEL_W    = 3;
	localparam int MADDR_LSB = 8;
	localparam int LIT_LSB   = 16;
	localparam int STAT_BUSY = 0;
	localparam int STAT_SKIP = 1;

	typedef enum logic [3:0] {
		OP_SUB_IMM,
		OP_SWAP,
		OP_SWAP_W,
		OP_SZ,
		OP_SZA,
		OP_SZ_BIT,
		OP_TRD_CUR,
		OP_TRD_LAST,
		OP_XOR_W,
		OP_XOR_M,
		OP_XOR_IMM
	} miet_op_e;

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_EXEC,
		ST_TABLE,
		ST_SKIP
	} miet_state_e;

endpackage

/* sim/miet_core_tb.sv */
// Purpose: self-checking bench for the execute tail core
// Assumes: data bytes sit at 0x100 + 4*i, only i below 64 is used here
// Notes:   a bench model predicts working, flags, data byte, table high, counter and status after each instruction
`timescale 1ns/1ps
module miet_core_tb;
	logic        ref_clk_i   = 1'b0;
	logic        rst_n_i     = 1'b0;
	logic        wb_cyc_i    = 1'b0;
	logic        wb_stb_i    = 1'b0;
	logic        wb_we_i     = 1'b0;
	logic [9:0]  wb_adr_i    = 10'h000;
	logic [3:0]  wb_sel_i    = 4'hF;
	logic [31:0] wb_dat_i    = 32'h00000000;
	logic [31:0] wb_dat_o;
	logic        wb_ack_o;
	logic [10:0] prog_addr_o;
	logic        prog_rd_o;
	logic [14:0] prog_data_i = 15'h0000;
	logic        busy_o;
	int          fail_count  = 0;
	int          checks_done = 0;
	int          cycles      = 0;
	int          rd_seen     = 0;
	logic [10:0] rd_addr;
	integer      seed        = 32'hD79D398B;

	always #4 ref_clk_i = ~ref_clk_i;

	miet_core #(.DEPTH(96), .PAW(11), .PW(15)) miet_core_i (
		.ref_clk_i  (ref_clk_i),
		.rst_n_i    (rst_n_i),
		.wb_cyc_i   (wb_cyc_i),
		.wb_stb_i   (wb_stb_i),
		.wb_we_i    (wb_we_i),
		.wb_adr_i   (wb_adr_i),
		.wb_sel_i   (wb_sel_i),
		.wb_dat_i   (wb_dat_i),
		.wb_dat_o   (wb_dat_o),
		.wb_ack_o   (wb_ack_o),
		.prog_addr_o(prog_addr_o),
		.prog_rd_o  (prog_rd_o),
		.prog_data_i(prog_data_i),
		.busy_o     (busy_o)
	);

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	task automatic tally_and_finish();
		if (fail_count == 0 && checks_done > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	// program fetches and the run limit
	always @(posedge ref_clk_i) begin
		cycles++;
		if (prog_rd_o === 1'b1) begin
			rd_seen++;
			rd_addr = prog_addr_o;
		end
		if (cycles == 20000) begin
			fail_count++;
			tally_and_finish();
		end
	end

	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		checks_done++;
		if (got !== exp) begin
			fail_count++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, got);
		end
	endtask

	// one classic cycle: raise after an edge, hold until ack is sampled
	task automatic wb(input logic we, input logic [9:0] a, input logic [31:0] d, output logic [31:0] q);
		int n;
		n = 0;
		@(posedge ref_clk_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i  <= we;
		wb_adr_i <= a;
		wb_dat_i <= d;
		do begin
			@(posedge ref_clk_i);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 20);
		q = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		if (n >= 20)
			chk("bus ack", 1, 0);
	endtask

	task automatic wr(input logic [9:0] a, input logic [31:0] d);
		logic [31:0] q;
		wb(1'b1, a, d, q);
	endtask

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		logic [31:0] q;
		logic [7:0]  acc, lit, m, tp, r, ea, em;
		logic [3:0]  fl, ef, op;
		logic [2:0]  bs;
		logic [5:0]  ad;
		logic [10:0] pc;
		logic [6:0]  thl;
		logic [14:0] w;
		logic        skip, et;
		int          cnt, rd0;
		thl = 7'h00;
		repeat (10) @(posedge ref_clk_i);
		rst_n_i <= 1'b1;
		wb(1'b0, miet_pkg::REG_WORKING, 32'h0, q);
		chk("working after reset", 32'h0, q);
		wb(1'b0, 10'h01C, 32'h0, q);
		chk("unmapped read", 32'h0, q);
		wr(miet_pkg::REG_TBL_HIGH, 32'h0000007F);
		for (int k = 0; k < 96; k++) begin
			op = k[3:0];
			acc = 8'($random(seed));
			lit = 8'($random(seed));
			m = 8'($random(seed));
			tp = 8'($random(seed));
			fl = 4'($random(seed));
			bs = 3'($random(seed));
			ad = 6'($random(seed));
			pc = 11'($random(seed));
			w = 15'($random(seed));
			if (k[4]) begin
				m = 8'h00;
				lit = acc;
				if (k[5])
					acc = 8'h00;
			end
			wr(miet_pkg::REG_WORKING, {24'h0, acc});
			wr(miet_pkg::REG_FLAGS, {28'h0, fl});
			wr(miet_pkg::REG_TBL_PTR, {24'h0, tp});
			wr(miet_pkg::REG_PROG_CNT, {21'h0, pc});
			wr(10'h100 + {2'b00, ad, 2'b00}, {24'h0, m});
			prog_data_i <= w;
			rd0 = rd_seen;
			ea = acc;
			em = m;
			ef = fl;
			skip = 1'b0;
			et = 1'b0;
			case (op)
				miet_pkg::OP_SUB_IMM: begin
					r = acc - lit;
					ea = r;
					ef = {(acc[7] != lit[7]) && (r[7] != acc[7]), r == 8'h00, acc[3:0] >= lit[3:0], acc >= lit};
				end
				miet_pkg::OP_SWAP:    em = {m[3:0], m[7:4]};
				miet_pkg::OP_SWAP_W:  ea = {m[3:0], m[7:4]};
				miet_pkg::OP_SZ:      skip = (m == 8'h00);
				miet_pkg::OP_SZA: begin
					ea = m;
					skip = (m == 8'h00);
				end
				miet_pkg::OP_SZ_BIT:  skip = !m[bs];
				miet_pkg::OP_TRD_CUR, miet_pkg::OP_TRD_LAST: begin
					em = w[7:0];
					thl = w[14:8];
					et = 1'b1;
				end
				miet_pkg::OP_XOR_W:   ea = acc ^ m;
				miet_pkg::OP_XOR_M:   em = acc ^ m;
				miet_pkg::OP_XOR_IMM: ea = acc ^ lit;
				default: ;
			endcase
			if (op == miet_pkg::OP_XOR_W || op == miet_pkg::OP_XOR_IMM)
				ef[2] = (ea == 8'h00);
			if (op == miet_pkg::OP_XOR_M)
				ef[2] = (em == 8'h00);
			wr(miet_pkg::REG_INSTR, {8'h00, lit, 2'b00, ad, 1'b0, bs, op});
			cnt = 0;
			do begin
				@(posedge ref_clk_i);
				if (busy_o === 1'b1)
					cnt++;
			end while (busy_o === 1'b1 && cnt < 8);
			chk("busy cycles", (skip || et) ? 2 : 1, cnt);
			chk("table fetches", et, rd_seen - rd0);
			if (et)
				chk("table address", {(op == miet_pkg::OP_TRD_LAST) ? 3'h7 : pc[10:8], tp}, rd_addr);
			wb(1'b0, miet_pkg::REG_WORKING, 32'h0, q);
			chk("working", {24'h0, ea}, q);
			wb(1'b0, miet_pkg::REG_FLAGS, 32'h0, q);
			chk("flags", {28'h0, ef}, q);
			wb(1'b0, 10'h100 + {2'b00, ad, 2'b00}, 32'h0, q);
			chk("data byte", {24'h0, em}, q);
			wb(1'b0, miet_pkg::REG_TBL_HIGH, 32'h0, q);
			chk("table high", {25'h0, thl}, q);
			wb(1'b0, miet_pkg::REG_PROG_CNT, 32'h0, q);
			chk("program counter", {21'h0, pc + (skip ? 11'h002 : 11'h001)}, q);
			wb(1'b0, miet_pkg::REG_STATUS, 32'h0, q);
			chk("status", {30'h0, skip, 1'b0}, q);
		end
		tally_and_finish();
	end
endmodule // miet_core_tb
